//--- pio_map.vh
// register offsets, field positions, vector layout, edge codes and timing counts
// for the strapped 16-line parallel port; included by both design files
//
// Functional notes
// RULE_01 - each input line strap selects live pin or latched bit on read
// RULE_02 - path straps default to latched bits on all sixteen lines
// RULE_03 - lines 15..12 latch on rising, falling or either edge by strap
// RULE_04 - edge straps default to falling, as lines 11..0 always do
// RULE_05 - per-bit strap lets each latch bit raise the input interrupt
// RULE_06 - address bits 12..3 compared with switch-set base
// RULE_07 - low address bits: 0 control, 2 inbound, 4 outbound
// RULE_08 - base switch off means one, on means zero
// RULE_09 - default base places registers at octal 16777x
// RULE_10 - vector bits 8..3 come from switches, on means one
// RULE_11 - vector bit 2 is zero for input, one for output
// RULE_12 - default vector switches give vector base octal 30x
// RULE_13 - three handshake outputs are single pulses, 1 us by default
// RULE_14 - each pulse width adjustable per line up to 5 us
// RULE_15 - each handshake line has own polarity strap, active low default
// RULE_16 - latch bits hold until software writes one to clear them
// RULE_17 - input enable clears on acknowledge; re-enable re-raises pending
// RULE_18 - writes to outbound word fire matching byte-loaded pulses
// RULE_19 - live pin read: low level reads one, high reads zero
// RULE_20 - straps are static inputs; pins synchronised before edge logic
// RULE_21 - far device samples data on trailing edge of byte-loaded pulse
`ifndef PIO_MAP_VH
`define PIO_MAP_VH

// ----------------------------------------------------------------------
// register selection
// ----------------------------------------------------------------------
`define PIO_OFS_CTL        3'h0
`define PIO_OFS_IN         3'h2
`define PIO_OFS_OUT        3'h4
`define PIO_IO_PAGE        3'h7

// ----------------------------------------------------------------------
// control_and_state fields
// ----------------------------------------------------------------------
`define PIO_CTL_MAINT_IN   5
`define PIO_CTL_IE_IN      6
`define PIO_CTL_USER_LO    7
`define PIO_CTL_MAINT_OUT  13
`define PIO_CTL_IE_OUT     14
`define PIO_CTL_USER_HI    15

// ----------------------------------------------------------------------
// vector layout and edge codes
// ----------------------------------------------------------------------
`define PIO_VEC_SEL_BIT    2
`define PIO_EDGE_FALL      2'h0
`define PIO_EDGE_RISE      2'h1

// ----------------------------------------------------------------------
// timing
// ----------------------------------------------------------------------
`define PIO_CLK_NS         10
`define PIO_PULSE_NS       1000
`define PIO_PULSE_MAX_NS   5000
`define PIO_PULSE_CYC      (`PIO_PULSE_NS / `PIO_CLK_NS)
`define PIO_PULSE_MAX_CYC  (`PIO_PULSE_MAX_NS / `PIO_CLK_NS)
`define PIO_CNT_W          9

`endif

//--- pio_pulse.v
// one handshake one-shot: fixed-width pulse with strapped polarity
// assumes trig is a one-cycle pulse on clk; retrigger while busy ignored
`timescale 1ns/1ns
`default_nettype none
`include "pio_map.vh"

module pio_pulse #(
  parameter integer WIDTH_NS = `PIO_PULSE_NS
) (
  input  wire       clk,
  input  wire       rst_b,
  input  wire       trig,
  input  wire       active_high,
  output reg        line
);

  // width clamps at the longest one-shot the cable option allows
  localparam integer CYC_RAW = (WIDTH_NS + `PIO_CLK_NS - 1) / `PIO_CLK_NS;
  localparam integer CYC_LIM = (CYC_RAW > `PIO_PULSE_MAX_CYC) ? `PIO_PULSE_MAX_CYC :
                               (CYC_RAW < 1) ? 1 : CYC_RAW;
  localparam [`PIO_CNT_W-1:0] CYC = CYC_LIM[`PIO_CNT_W-1:0];

  reg [`PIO_CNT_W-1:0] count;
  wire                 busy;
  wire                 next_on;

  assign busy    = (count != {`PIO_CNT_W{1'b0}});
  assign next_on = busy ? (count != {{(`PIO_CNT_W-1){1'b0}}, 1'b1}) : trig;

  always @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      count <= {`PIO_CNT_W{1'b0}};
      line  <= 1'b1;
    end else begin
      if (busy)
        count <= count - {{(`PIO_CNT_W-1){1'b0}}, 1'b1};
      else if (trig)
        count <= CYC; // RULE_13 RULE_14
      line <= next_on ? active_high : ~active_high; // RULE_15
    end
  end

endmodule // pio_pulse
`default_nettype wire

//--- pio_port.v
// strapped 16-line parallel port: host register side, input latches,
// vectored interrupt request and three handshake one-shots
// assumes host strobes are one-cycle pulses on clk; pins are asynchronous
`timescale 1ns/1ns
`default_nettype none
`include "pio_map.vh"

module pio_port #(
  parameter integer ACCEPT_NS  = `PIO_PULSE_NS,
  parameter integer HI_NS      = `PIO_PULSE_NS,
  parameter integer LO_NS      = `PIO_PULSE_NS
) (
  input  wire        clk,
  input  wire        rst_b,
  // host bus
  input  wire [15:0] host_addr,
  input  wire        host_rd,
  input  wire        host_wr,
  input  wire        host_byte,
  input  wire [15:0] host_wdata,
  output reg  [15:0] host_rdata,
  output reg         host_ack,
  output reg         intr_req,
  input  wire        intr_grant,
  output reg  [15:0] vec_data,
  output reg         vec_valid,
  // static straps
  input  wire [15:0] strap_direct,
  input  wire [7:0]  strap_edge,
  input  wire [15:0] strap_irq_en,
  input  wire [9:0]  strap_base_sw,
  input  wire [5:0]  strap_vec_sw,
  input  wire [2:0]  strap_pol_high,
  // user device
  input  wire [15:0] data_in_pin,
  input  wire        ext_ready_pin,
  input  wire        ext_accepted_pin,
  output reg  [15:0] data_out,
  output wire        data_accept_line,
  output wire        hi_loaded_line,
  output wire        lo_loaded_line
);

  // --------------------------------------------------------------------
  // pin synchronisers
  // --------------------------------------------------------------------
  reg  [17:0] sync_a;
  reg  [17:0] sync_b;
  reg  [17:0] sync_prev;
  wire [15:0] pin_s;
  wire [15:0] pin_fall;
  wire [15:0] pin_rise;
  wire        ready_fall;
  wire        accepted_fall;

  always @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      sync_a    <= {18{1'b1}};
      sync_b    <= {18{1'b1}};
      sync_prev <= {18{1'b1}};
    end else begin
      sync_a    <= {ext_accepted_pin, ext_ready_pin, data_in_pin}; // RULE_20
      sync_b    <= sync_a;
      sync_prev <= sync_b;
    end
  end

  assign pin_s         = sync_b[15:0];
  assign pin_fall      = sync_prev[15:0] & ~sync_b[15:0];
  assign pin_rise      = ~sync_prev[15:0] & sync_b[15:0];
  assign ready_fall    = sync_prev[16] & ~sync_b[16];
  assign accepted_fall = sync_prev[17] & ~sync_b[17];

  // --------------------------------------------------------------------
  // address decode
  // --------------------------------------------------------------------
  wire       hit;
  wire       sel_ctl;
  wire       sel_in;
  wire       sel_out;
  wire       wr_hi;
  wire       wr_lo;
  wire       mapped;
  wire [15:0] wmask;

  // base switch on reads as zero, so the compare uses the inverse
  assign hit = (host_addr[15:13] == `PIO_IO_PAGE) &&
               (host_addr[12:3] == ~strap_base_sw); // RULE_06 RULE_08 RULE_09
  assign sel_ctl = hit && (host_addr[2:0] == `PIO_OFS_CTL); // RULE_07
  assign sel_in  = hit && (host_addr[2:0] == `PIO_OFS_IN);
  assign sel_out = hit && ({host_addr[2:1], 1'b0} == `PIO_OFS_OUT);
  // offsets 1, 3, 6 and 7 inside the base stay silent
  assign mapped  = sel_ctl || sel_in || sel_out;
  // byte write picks its lane from address bit 0
  assign wr_hi = host_wr && (!host_byte || host_addr[0]);
  assign wr_lo = host_wr && (!host_byte || !host_addr[0]);
  assign wmask = {{8{wr_hi}}, {8{wr_lo}}};

  // --------------------------------------------------------------------
  // input latches
  // --------------------------------------------------------------------
  reg  [15:0] latch;
  wire [15:0] latch_set;
  wire [15:0] latch_clr;

  genvar g;
  generate
    for (g = 0; g < 16; g = g + 1) begin : g_edge
      if (g >= 12) begin : g_sel
        wire [1:0] code = strap_edge[2*(g-12)+1 : 2*(g-12)];
        assign latch_set[g] = (code == `PIO_EDGE_FALL) ? pin_fall[g] :
                              (code == `PIO_EDGE_RISE) ? pin_rise[g] :
                              (pin_fall[g] | pin_rise[g]); // RULE_03 RULE_04
      end else begin : g_fix
        assign latch_set[g] = pin_fall[g]; // RULE_04
      end
    end
  endgenerate

  assign latch_clr = (sel_in && host_wr) ? (host_wdata & wmask) : 16'h0000;

  always @(posedge clk or negedge rst_b) begin
    if (!rst_b)
      latch <= 16'h0000;
    else
      latch <= latch_set | (latch & ~latch_clr); // RULE_16
  end

  // --------------------------------------------------------------------
  // control_and_state and outbound_word
  // --------------------------------------------------------------------
  reg ie_in;
  reg ie_out;
  reg user_lo;
  reg user_hi;
  reg maint_in;
  reg maint_out;
  reg ready_flag;
  reg accepted_flag;
  reg grant_in;
  reg grant_out;

  always @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      ie_in     <= 1'b0;
      ie_out    <= 1'b0;
      user_lo   <= 1'b0;
      user_hi   <= 1'b0;
      maint_in  <= 1'b0;
      maint_out <= 1'b0;
      data_out  <= 16'h0000;
    end else begin
      if (sel_ctl && wr_lo) begin
        user_lo  <= host_wdata[`PIO_CTL_USER_LO];
        maint_in <= host_wdata[`PIO_CTL_MAINT_IN];
        ie_in    <= host_wdata[`PIO_CTL_IE_IN];
      end else if (grant_in)
        ie_in <= 1'b0; // RULE_17
      if (sel_ctl && wr_hi) begin
        user_hi   <= host_wdata[`PIO_CTL_USER_HI];
        maint_out <= host_wdata[`PIO_CTL_MAINT_OUT];
        ie_out    <= host_wdata[`PIO_CTL_IE_OUT];
      end else if (grant_out)
        ie_out <= 1'b0;
      if (sel_out)
        data_out <= (host_wdata & wmask) | (data_out & ~wmask);
    end
  end

  // --------------------------------------------------------------------
  // host read and acknowledge
  // --------------------------------------------------------------------
  wire [15:0] in_view;
  reg  [15:0] next_rdata;

  // live pins read inverted: a low line is a logical one
  assign in_view = (strap_direct & ~pin_s) | (~strap_direct & latch); // RULE_01 RULE_02 RULE_19

  always @* begin
    next_rdata = 16'h0000;
    if (sel_ctl) begin
      next_rdata[`PIO_CTL_IE_IN]   = ie_in;
      next_rdata[`PIO_CTL_USER_LO] = user_lo;
      next_rdata[`PIO_CTL_IE_OUT]  = ie_out;
      next_rdata[`PIO_CTL_USER_HI] = user_hi;
    end else if (sel_in)
      next_rdata = in_view;
    else if (sel_out)
      next_rdata = data_out;
  end

  always @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      host_rdata <= 16'h0000;
      host_ack   <= 1'b0;
    end else begin
      host_ack <= mapped && (host_rd || host_wr); // RULE_07
      if (mapped && host_rd)
        host_rdata <= next_rdata;
    end
  end

  // --------------------------------------------------------------------
  // interrupt request and vector
  // --------------------------------------------------------------------
  wire in_pend;
  wire out_pend;
  wire in_act;
  wire out_act;

  assign in_pend  = (|(latch & strap_irq_en)) | ready_flag | maint_in; // RULE_05
  assign out_pend = accepted_flag | maint_out;
  // pending latch bits re-raise the request once the enable is back
  assign in_act   = in_pend && ie_in; // RULE_17
  assign out_act  = out_pend && ie_out;

  always @* begin
    grant_in  = intr_grant && intr_req && in_act;
    grant_out = intr_grant && intr_req && !in_act && out_act;
  end

  always @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      ready_flag    <= 1'b0;
      accepted_flag <= 1'b0;
      intr_req      <= 1'b0;
      vec_data      <= 16'h0000;
      vec_valid     <= 1'b0;
    end else begin
      // a fresh edge in the grant cycle survives the clear
      ready_flag    <= ready_fall | (ready_flag & ~grant_in);
      accepted_flag <= accepted_fall | (accepted_flag & ~grant_out);
      intr_req      <= (in_act || out_act) && !(grant_in || grant_out);
      vec_valid     <= grant_in || grant_out;
      if (grant_in || grant_out)
        vec_data <= {7'h00, strap_vec_sw, grant_out, 2'h0}; // RULE_10 RULE_11 RULE_12
    end
  end

  // --------------------------------------------------------------------
  // handshake one-shots
  // --------------------------------------------------------------------
  wire [2:0] shot_trig;
  reg  [2:0] shot_line;
  wire [2:0] shot_raw;

  assign shot_trig[0] = sel_in && host_rd;
  assign shot_trig[1] = sel_out && wr_hi; // RULE_18
  assign shot_trig[2] = sel_out && wr_lo; // RULE_18

  generate
    for (g = 0; g < 3; g = g + 1) begin : g_shot
      pio_pulse #(
        .WIDTH_NS   ((g == 0) ? ACCEPT_NS : (g == 1) ? HI_NS : LO_NS)
      ) u_shot (
        .clk         (clk),
        .rst_b       (rst_b),
        .trig        (shot_trig[g]),
        .active_high (strap_pol_high[g]),
        .line        (shot_raw[g])
      );
    end
  endgenerate

  always @* begin
    shot_line = shot_raw;
  end

  // data is loaded at the leading edge so the far side can sample at trailing
  assign data_accept_line = shot_line[0];
  assign hi_loaded_line   = shot_line[1]; // RULE_21
  assign lo_loaded_line   = shot_line[2];

endmodule // pio_port
`default_nettype wire

//--- pio_port_sva.sv
// checker for the strapped parallel port, bound into pio_port
// assumes static straps and one-cycle host strobes
`timescale 1ns/1ns
`default_nettype none
module pio_chk #(
  parameter integer LO_NS = 1000
) (
  input wire logic        clk,
  input wire logic        rst_b,
  input wire logic [15:0] host_addr,
  input wire logic        host_rd,
  input wire logic        host_wr,
  input wire logic        host_byte,
  input wire logic        host_ack,
  input wire logic        intr_req,
  input wire logic        intr_grant,
  input wire logic [15:0] vec_data,
  input wire logic        vec_valid,
  input wire logic [9:0]  strap_base_sw,
  input wire logic [5:0]  strap_vec_sw,
  input wire logic [2:0]  strap_pol_high,
  input wire logic        data_accept_line,
  input wire logic        hi_loaded_line,
  input wire logic        lo_loaded_line
);
  // ----------------------------------------------------------------
  // decode and pulse-width helper
  // ----------------------------------------------------------------
  localparam integer LO_CYC = (LO_NS + 9) / 10;
  wire logic hit = host_addr[15:13] == 3'h7 && host_addr[12:3] == ~strap_base_sw
                   && host_addr[2:0] != 3'h1 && host_addr[2:0] != 3'h3 && !(&host_addr[2:1]);
  logic       seen;
  logic [9:0] run;
  // reset level of the line is not a pulse, so counting waits one edge
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      seen <= 1'b0;
      run  <= 10'h0;
    end else begin
      seen <= 1'b1;
      run  <= (seen && lo_loaded_line == strap_pol_high[2]) ? run + 10'h1 : 10'h0;
    end
  end
  // ----------------------------------------------------------------
  // properties
  // ----------------------------------------------------------------
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_b);
  sequence out_word_s; host_wr && hit && host_addr[2:1] == 2'h2 && !host_byte; endsequence
  sequence hi_byte_s; host_wr && hit && host_addr[2:0] == 3'h5 && host_byte; endsequence
  sequence in_read_s; host_rd && hit && host_addr[2:0] == 3'h2; endsequence
  hit_ack_a:
    assert property ((host_rd || host_wr) && hit |=> host_ack) else $error("no ack on hit");
  miss_ack_a:
    assert property ((host_rd || host_wr) && !hit |=> !host_ack) else $error("ack on miss");
  vec_fmt_a:
    assert property (vec_valid |-> vec_data[15:9] == 7'h0 && vec_data[8:3] == strap_vec_sw
      && vec_data[1:0] == 2'h0) else $error("bad vector");
  grant_vec_a:
    assert property (intr_grant && intr_req |=> vec_valid && !intr_req) else $error("grant");
  stray_grant_a:
    assert property (intr_grant && !intr_req |=> !vec_valid) else $error("stray vector");
  word_pulse_a:
    assert property (out_word_s |-> ##2 lo_loaded_line == strap_pol_high[2]
      && hi_loaded_line == strap_pol_high[1]) else $error("word pulses");
  hi_only_a:
    assert property (hi_byte_s |-> ##2 hi_loaded_line == strap_pol_high[1]
      && lo_loaded_line != strap_pol_high[2]) else $error("upper byte pulse");
  accept_pulse_a:
    assert property (in_read_s |-> ##2 data_accept_line == strap_pol_high[0])
      else $error("accept pulse");
  lo_width_a:
    assert property ($fell(run != 10'h0) |-> $past(run) == LO_CYC) else $error("lo width");
endmodule // pio_chk
bind pio_port pio_chk #(.LO_NS(LO_NS)) chk (.clk, .rst_b, .host_addr, .host_rd, .host_wr,
  .host_byte, .host_ack, .intr_req, .intr_grant, .vec_data, .vec_valid, .strap_base_sw,
  .strap_vec_sw, .strap_pol_high, .data_accept_line, .hi_loaded_line, .lo_loaded_line);
`default_nettype wire

//--- pio_dev.sv
// user device model: drives data pins and the two strobes,
// takes outbound bytes on the trailing edge of each loaded pulse
`timescale 1ns/1ns
`default_nettype none
module pio_dev (
  input  wire logic        clk,
  input  wire logic [15:0] data_out,
  input  wire logic        hi_loaded_line,
  input  wire logic        lo_loaded_line,
  input  wire logic [2:0]  strap_pol_high,
  output var  logic [15:0] data_in_pin,
  output var  logic        ext_ready_pin,
  output var  logic        ext_accepted_pin
);
  // ----------------------------------------------------------------
  // pins and capture
  // ----------------------------------------------------------------
  logic       hi_q, lo_q;
  logic [7:0] cap_hi = 8'h0, cap_lo = 8'h0;
  initial data_in_pin = 16'hffff;
  initial ext_ready_pin = 1'b1;
  initial ext_accepted_pin = 1'b1;
  // waits out synchroniser and latch so the next read sees the change
  task automatic set_pins(input logic [15:0] v);
    data_in_pin = v;
    repeat (4) @(negedge clk);
  endtask
  // low-going strobe, held long enough for the synchroniser
  task automatic strobe(input logic out_side);
    @(negedge clk);
    if (out_side) ext_accepted_pin = 1'b0;
    else ext_ready_pin = 1'b0;
    repeat (3) @(negedge clk);
    ext_accepted_pin = 1'b1;
    ext_ready_pin = 1'b1;
  endtask
  always @(posedge clk) begin
    hi_q <= hi_loaded_line;
    lo_q <= lo_loaded_line;
    if (hi_q == strap_pol_high[1] && hi_loaded_line != strap_pol_high[1]) cap_hi <= data_out[15:8];
    if (lo_q == strap_pol_high[2] && lo_loaded_line != strap_pol_high[2]) cap_lo <= data_out[7:0];
  end
endmodule // pio_dev
`default_nettype wire

//--- parallel_io_strap_options_tb.sv
// self-checking bench for the strapped parallel port
// assumes pio_port, its checker and the pio_dev device model
`timescale 1ns/1ns
`default_nettype none
`define CHK(nm, ex, gt) begin cmp_count++; if ((gt) !== (ex)) begin n_fail++; $display("mismatch %s exp %h got %h", nm, ex, gt); end end
module parallel_io_strap_options_tb;
  localparam logic [15:0] CTL = 16'heff8, INP = 16'heffa, OUTW = 16'heffc;
  logic        clk = 1'b0, rst_b = 1'b0, host_rd = 1'b0, host_wr = 1'b0;
  logic        host_byte = 1'b0, intr_grant = 1'b0;
  logic [15:0] host_addr = 16'h0, host_wdata = 16'h0, last;
  logic [15:0] strap_direct = 16'h000f, strap_irq_en = 16'h1000;
  logic [7:0]  strap_edge = 8'he4;
  logic [9:0]  strap_base_sw = 10'h200;
  logic [5:0]  strap_vec_sw = 6'h18;
  logic [2:0]  strap_pol_high = 3'h3;
  wire  logic [15:0] host_rdata, vec_data, data_in_pin, data_out;
  wire  logic  host_ack, intr_req, vec_valid, ext_ready_pin, ext_accepted_pin;
  wire  logic  data_accept_line, hi_loaded_line, lo_loaded_line;
  int          n_fail = 0, cmp_count = 0;
  always #5 clk = ~clk;
  pio_port #(.ACCEPT_NS(50), .HI_NS(50), .LO_NS(50)) dut (.clk, .rst_b, .host_addr, .host_rd,
    .host_wr, .host_byte, .host_wdata, .host_rdata, .host_ack, .intr_req, .intr_grant,
    .vec_data, .vec_valid, .strap_direct, .strap_edge, .strap_irq_en, .strap_base_sw,
    .strap_vec_sw, .strap_pol_high, .data_in_pin, .ext_ready_pin, .ext_accepted_pin,
    .data_out, .data_accept_line, .hi_loaded_line, .lo_loaded_line);
  pio_dev dev (.clk, .data_out, .hi_loaded_line, .lo_loaded_line, .strap_pol_high,
    .data_in_pin, .ext_ready_pin, .ext_accepted_pin);
  // ----------------------------------------------------------------
  // host access tasks
  // ----------------------------------------------------------------
  // idle gap after each access keeps one-shots from being retriggered
  task automatic acc(input logic w, input logic bt, input logic [15:0] a, input logic [15:0] d,
                     input logic ak);
    @(negedge clk);
    host_addr = a;
    host_wdata = d;
    host_byte = bt;
    host_wr = w;
    host_rd = !w;
    @(negedge clk);
    host_wr = 1'b0;
    host_rd = 1'b0;
    `CHK("ack", ak, host_ack)
    last = host_rdata;
    repeat (8) @(negedge clk);
  endtask
  task automatic rd(input logic [15:0] a, input logic [15:0] ex);
    acc(1'b0, 1'b0, a, 16'h0, 1'b1);
    `CHK("rdata", ex, last)
  endtask
  task automatic take_irq(input logic [15:0] ex);
    int k;
    k = 0;
    while (intr_req !== 1'b1 && k < 20) begin
      @(negedge clk);
      k++;
    end
    intr_grant = 1'b1;
    @(negedge clk);
    intr_grant = 1'b0;
    `CHK("vec_valid", 1'b1, vec_valid)
    `CHK("vector", ex, vec_data)
  endtask
  task automatic report_and_stop;
    $display("comparisons %0d mismatches %0d", cmp_count, n_fail);
    if (n_fail == 0 && cmp_count > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask
  // ----------------------------------------------------------------
  // scenarios
  // ----------------------------------------------------------------
  initial begin
    repeat (4) @(negedge clk);
    rst_b = 1'b1;
    @(negedge clk);
    `CHK("accept idle", 1'b0, data_accept_line)
    `CHK("lo idle", 1'b1, lo_loaded_line)
    acc(1'b1, 1'b0, CTL, 16'hc0c0, 1'b1);
    rd(CTL, 16'hc0c0);
    acc(1'b0, 1'b0, 16'heffe, 16'h0, 1'b0);
    acc(1'b0, 1'b0, 16'heff0, 16'h0, 1'b0);
    acc(1'b1, 1'b0, CTL, 16'h0060, 1'b1);
    take_irq(16'h00c0);
    rd(CTL, 16'h0000);
    acc(1'b1, 1'b0, CTL, 16'h4000, 1'b1);
    dev.strobe(1'b1);
    take_irq(16'h00c4);
    acc(1'b1, 1'b0, CTL, 16'h0040, 1'b1);
    dev.strobe(1'b0);
    take_irq(16'h00c0);
    dev.set_pins(16'h0fef);
    rd(INP, 16'hd010);
    acc(1'b1, 1'b0, CTL, 16'h0040, 1'b1);
    take_irq(16'h00c0);
    acc(1'b1, 1'b0, CTL, 16'h0040, 1'b1);
    take_irq(16'h00c0);
    acc(1'b1, 1'b0, INP, 16'h1000, 1'b1);
    rd(INP, 16'hc010);
    acc(1'b1, 1'b0, INP, 16'hc010, 1'b1);
    dev.set_pins(16'hfff5);
    rd(INP, 16'he00a);
    acc(1'b1, 1'b0, INP, 16'hffff, 1'b1);
    rd(INP, 16'h000a);
    acc(1'b1, 1'b0, OUTW, 16'h1234, 1'b1);
    rd(OUTW, 16'h1234);
    `CHK("dev hi", 8'h12, dev.cap_hi)
    `CHK("dev lo", 8'h34, dev.cap_lo)
    acc(1'b1, 1'b1, 16'heffd, 16'hab00, 1'b1);
    acc(1'b1, 1'b1, OUTW, 16'h00cd, 1'b1);
    rd(OUTW, 16'habcd);
    `CHK("dev hi byte", 8'hab, dev.cap_hi)
    `CHK("dev lo byte", 8'hcd, dev.cap_lo)
    intr_grant = 1'b1;
    @(negedge clk);
    intr_grant = 1'b0;
    `CHK("stray vec", 1'b0, vec_valid)
    // second reset with default straps: active-low lines, latched, falling edges
    @(negedge clk);
    rst_b = 1'b0;
    strap_pol_high = 3'h0;
    strap_direct = 16'h0000;
    strap_edge = 8'h00;
    repeat (4) @(negedge clk);
    rst_b = 1'b1;
    @(negedge clk);
    `CHK("accept idle low", 1'b1, data_accept_line)
    `CHK("hi idle low", 1'b1, hi_loaded_line)
    rd(CTL, 16'h0000);
    acc(1'b1, 1'b0, OUTW, 16'h5aa5, 1'b1);
    `CHK("dev hi low pol", 8'h5a, dev.cap_hi)
    `CHK("dev lo low pol", 8'ha5, dev.cap_lo)
    rd(INP, 16'h000a);
    dev.set_pins(16'h7ff5);
    rd(INP, 16'h800a);
    report_and_stop();
  end
  // whole sequence needs under 1000 cycles
  initial begin
    #100000;
    n_fail++;
    report_and_stop();
  end
endmodule // parallel_io_strap_options_tb
`default_nettype wire
